// ### design/psr_config_regs.v
/*
 * Paged phase shedding and ramp configuration registers of a dual channel
 * controller, with the shedding and ramp logic they steer.
 * Assumes a PMBus engine outside decodes each transaction into one command
 * strobe with its code, kind and data word, and takes one response back.
 */
// Operation
// - Each channel has its own copy of both registers, chosen by page 00h for A and 01h for B.
// - The registers are reached only by word read and word write commands.
// - Bits 9:8 set the three to two drop threshold as twice peak efficiency current minus 2, plus 0, 2, 4 or 6 A.
// - Three phases fall to two when the average phase current reaches that threshold.
// - Bit 7 of the first register disables shedding at 0 and enables it at 1.
// - Bits 6:5 choose the undershoot level one ramp: base, 40, 80 or 120 mV.
// - Bit 4 forces a 120 mV ramp in two phase operation, else the base ramp.
// - Bit 3 forces an 80 mV ramp in one phase operation, else the base ramp.
// - Bits 2:0 pick a base ramp of 40 to 320 mV in 40 mV steps, ascending with the code.
// - Bits 15:10 of the first register are stored and read back but steer nothing.
// - Bit 15 of the second register enables discontinuous mode in one phase operation after shedding.
// - Bits 14:13 of the second register set the two to one threshold as peak current minus 2, plus 0, 2, 4 or 6 A.
// - Peak efficiency current per phase is 12, 14, 16 or 18 A by its two bit select.
`include "psr_consts.vh"

module psr_config_regs #(
    parameter CH_A_PHASES = 3,
    parameter CH_B_PHASES = 1
) (
    input wire CLOCK,
    input wire RESET,
    input wire CMD_VALID,
    input wire CMD_READ,
    input wire CMD_IS_WORD,
    input wire [7:0] CMD_CODE,
    input wire [15:0] CMD_WDATA,
    input wire [15:0] NVM_DROP_RAMP_A,
    input wire [15:0] NVM_SHED_TH_A,
    input wire [15:0] NVM_DROP_RAMP_B,
    input wire [15:0] NVM_SHED_TH_B,
    input wire [7:0] AVG_CURRENT_A,
    input wire [7:0] AVG_CURRENT_B,
    input wire USR_LEVEL1_A,
    input wire USR_LEVEL1_B,
    output reg RSP_VALID,
    output reg RSP_ERROR,
    output reg [15:0] RSP_RDATA,
    output reg [7:0] PAGE_SEL,
    output reg [2:0] PHASE_STATE_A,
    output reg [2:0] PHASE_STATE_B,
    output reg [2:0] RAMP_STEP_A,
    output reg [2:0] RAMP_STEP_B,
    output reg DCM_ENABLE_A,
    output reg DCM_ENABLE_B
);

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    wire hit_page = CMD_CODE == `PSR_CMD_PAGE;
    wire hit_drc = CMD_CODE == `PSR_CMD_DROP_RAMP;
    wire hit_stc = CMD_CODE == `PSR_CMD_SHED_TH;
    // Byte access to a word register is refused whole, never half applied.
    wire word_ok = (hit_drc || hit_stc) && CMD_IS_WORD;
    wire page_ok = hit_page && !CMD_IS_WORD;
    wire page_val_ok = CMD_WDATA[7:0] == `PSR_PAGE_CH_A || CMD_WDATA[7:0] == `PSR_PAGE_CH_B;
    wire sel_a = PAGE_SEL == `PSR_PAGE_CH_A;
    wire do_write = CMD_VALID && !CMD_READ && word_ok;

    wire wr_drc_a = do_write && hit_drc && sel_a;
    wire wr_stc_a = do_write && hit_stc && sel_a;
    wire wr_drc_b = do_write && hit_drc && !sel_a;
    wire wr_stc_b = do_write && hit_stc && !sel_a;

    wire [15:0] drc_a;
    wire [15:0] stc_a;
    wire [15:0] drc_b;
    wire [15:0] stc_b;

    // ----------------------------------------------------------------
    // Channel copies
    // ----------------------------------------------------------------
    psr_chan_store u_store_a (
        .clk(CLOCK),
        .rst(RESET),
        .nvm_drop_ramp(NVM_DROP_RAMP_A),
        .nvm_shed_th(NVM_SHED_TH_A),
        .wr_drop_ramp(wr_drc_a),
        .wr_shed_th(wr_stc_a),
        .wr_data(CMD_WDATA),
        .drop_ramp_ff(drc_a),
        .shed_th_ff(stc_a)
    );

    psr_chan_store u_store_b (
        .clk(CLOCK),
        .rst(RESET),
        .nvm_drop_ramp(NVM_DROP_RAMP_B),
        .nvm_shed_th(NVM_SHED_TH_B),
        .wr_drop_ramp(wr_drc_b),
        .wr_shed_th(wr_stc_b),
        .wr_data(CMD_WDATA),
        .drop_ramp_ff(drc_b),
        .shed_th_ff(stc_b)
    );

    wire [2:0] st_a;
    wire [2:0] st_b;
    wire [2:0] rs_a;
    wire [2:0] rs_b;
    wire dcm_a;
    wire dcm_b;

    psr_shed_ctrl #(.MAX_PH(CH_A_PHASES)) u_shed_a (
        .clk(CLOCK),
        .rst(RESET),
        .drop_ramp(drc_a),
        .shed_th(stc_a),
        .avg_current(AVG_CURRENT_A),
        .usr_level1(USR_LEVEL1_A),
        .phase_state_ff(st_a),
        .ramp_step(rs_a),
        .dcm_en(dcm_a)
    );

    psr_shed_ctrl #(.MAX_PH(CH_B_PHASES)) u_shed_b (
        .clk(CLOCK),
        .rst(RESET),
        .drop_ramp(drc_b),
        .shed_th(stc_b),
        .avg_current(AVG_CURRENT_B),
        .usr_level1(USR_LEVEL1_B),
        .phase_state_ff(st_b),
        .ramp_step(rs_b),
        .dcm_en(dcm_b)
    );

    // ----------------------------------------------------------------
    // Response and page
    // ----------------------------------------------------------------
    reg [15:0] nxt_rdata;
    reg nxt_error;
    always @* begin
        nxt_rdata = 16'h0000;
        nxt_error = 1'b0;
        if (page_ok) begin
            if (CMD_READ) begin
                nxt_rdata = {8'h00, PAGE_SEL};
            end else begin
                nxt_error = !page_val_ok;
            end
        end else if (word_ok) begin
            if (CMD_READ) begin
                if (hit_drc) begin
                    nxt_rdata = sel_a ? drc_a : drc_b;
                end else begin
                    nxt_rdata = sel_a ? stc_a : stc_b;
                end
            end
        end else begin
            nxt_error = 1'b1;
        end
    end

    always @(posedge CLOCK) begin
        if (RESET) begin
            RSP_VALID <= 1'b0;
            RSP_ERROR <= 1'b0;
            RSP_RDATA <= 16'h0000;
            PAGE_SEL <= `PSR_PAGE_RESET;
        end else begin
            RSP_VALID <= CMD_VALID;
            if (CMD_VALID) begin
                RSP_ERROR <= nxt_error;
                RSP_RDATA <= nxt_rdata;
                if (page_ok && !CMD_READ && page_val_ok) begin
                    PAGE_SEL <= CMD_WDATA[7:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Registered controls toward the regulation loop
    // ----------------------------------------------------------------
    always @(posedge CLOCK) begin
        if (RESET) begin
            PHASE_STATE_A <= 3'h0;
            PHASE_STATE_B <= 3'h0;
            RAMP_STEP_A <= 3'h0;
            RAMP_STEP_B <= 3'h0;
            DCM_ENABLE_A <= 1'b0;
            DCM_ENABLE_B <= 1'b0;
        end else begin
            PHASE_STATE_A <= st_a;
            PHASE_STATE_B <= st_b;
            RAMP_STEP_A <= rs_a;
            RAMP_STEP_B <= rs_b;
            DCM_ENABLE_A <= dcm_a;
            DCM_ENABLE_B <= dcm_b;
        end
    end

endmodule // psr_config_regs

// ### design/psr_consts.vh
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH

// ----------------------------------------------------------------
// Command codes and channel page values
// ----------------------------------------------------------------
`define PSR_CMD_PAGE 8'h00
`define PSR_CMD_DROP_RAMP 8'hDE
`define PSR_CMD_SHED_TH 8'hDF
`define PSR_PAGE_CH_A 8'h00
`define PSR_PAGE_CH_B 8'h01
`define PSR_PAGE_RESET 8'h00

// ----------------------------------------------------------------
// Field positions of phase_drop_ramp_config
// ----------------------------------------------------------------
`define PSR_DRC_DROP32_HI 9
`define PSR_DRC_DROP32_LO 8
`define PSR_DRC_SHED_EN 7
`define PSR_DRC_USR_HI 6
`define PSR_DRC_USR_LO 5
`define PSR_DRC_OV2PH 4
`define PSR_DRC_OV1PH 3
`define PSR_DRC_RAMP_HI 2
`define PSR_DRC_RAMP_LO 0

// ----------------------------------------------------------------
// Field positions of phase_shed_threshold_config
// ----------------------------------------------------------------
`define PSR_STC_DCM 15
`define PSR_STC_DROP21_HI 14
`define PSR_STC_DROP21_LO 13
`define PSR_STC_PEAK_HI 1
`define PSR_STC_PEAK_LO 0

// ----------------------------------------------------------------
// Ramp step codes, amplitude is (code + 1) x 40 mV
// ----------------------------------------------------------------
`define PSR_RAMP_80MV 3'h1
`define PSR_RAMP_120MV 3'h2

// ----------------------------------------------------------------
// Current arithmetic in amperes
// ----------------------------------------------------------------
`define PSR_PEAK_BASE_A 8'h0C
`define PSR_FINE_BIAS_A 8'h02
`define PSR_ADD_HYST_A 8'h04

`endif

// ### design/psr_chan_store.v
/*
 * Per-channel storage of the two configuration words.
 * Assumes the nonvolatile image is stable while RESET is high.
 */
module psr_chan_store (
    input wire clk,
    input wire rst,
    input wire [15:0] nvm_drop_ramp,
    input wire [15:0] nvm_shed_th,
    input wire wr_drop_ramp,
    input wire wr_shed_th,
    input wire [15:0] wr_data,
    output reg [15:0] drop_ramp_ff,
    output reg [15:0] shed_th_ff
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // All sixteen bits are kept so spare bits read back what was written.
    always @(posedge clk) begin
        if (rst) begin
            drop_ramp_ff <= nvm_drop_ramp;
            shed_th_ff <= nvm_shed_th;
        end else begin
            if (wr_drop_ramp) begin
                drop_ramp_ff <= wr_data;
            end
            if (wr_shed_th) begin
                shed_th_ff <= wr_data;
            end
        end
    end

endmodule // psr_chan_store

// ### design/psr_shed_ctrl.v
/*
 * Phase shedding decision and ramp amplitude selection for one channel.
 * Assumes the average phase current is an unsigned count of amperes.
 */
`include "psr_consts.vh"

module psr_shed_ctrl #(
    parameter MAX_PH = 3
) (
    input wire clk,
    input wire rst,
    input wire [15:0] drop_ramp,
    input wire [15:0] shed_th,
    input wire [7:0] avg_current,
    input wire usr_level1,
    output reg [2:0] phase_state_ff,
    output reg [2:0] ramp_step,
    output reg dcm_en
);

    localparam ST_3PH = 3'b001;
    localparam ST_2PH = 3'b010;
    localparam ST_1PH = 3'b100;
    localparam [2:0] ST_MAX = (MAX_PH >= 3) ? ST_3PH : ((MAX_PH == 2) ? ST_2PH : ST_1PH);

    wire shed_en = drop_ramp[`PSR_DRC_SHED_EN];
    wire [1:0] peak_sel = shed_th[`PSR_STC_PEAK_HI:`PSR_STC_PEAK_LO];
    wire [1:0] fine32 = drop_ramp[`PSR_DRC_DROP32_HI:`PSR_DRC_DROP32_LO];
    wire [1:0] fine21 = shed_th[`PSR_STC_DROP21_HI:`PSR_STC_DROP21_LO];
    wire [1:0] usr_sel = drop_ramp[`PSR_DRC_USR_HI:`PSR_DRC_USR_LO];

    // ----------------------------------------------------------------
    // Thresholds
    // ----------------------------------------------------------------
    wire [7:0] peak_a = `PSR_PEAK_BASE_A + {5'h00, peak_sel, 1'b0};
    wire [8:0] thr32 = {peak_a, 1'b0} + {6'h00, fine32, 1'b0} - {1'b0, `PSR_FINE_BIAS_A};
    wire [8:0] thr21 = {1'b0, peak_a} + {6'h00, fine21, 1'b0} - {1'b0, `PSR_FINE_BIAS_A};
    wire [8:0] avg9 = {1'b0, avg_current};
    wire [8:0] hyst9 = {1'b0, `PSR_ADD_HYST_A};

    // ----------------------------------------------------------------
    // Phase state
    // ----------------------------------------------------------------
    reg [2:0] nxt_phase_state;
    always @* begin
        nxt_phase_state = phase_state_ff;
        if (!shed_en) begin
            nxt_phase_state = ST_MAX;
        end else begin
            case (phase_state_ff)
                ST_3PH: begin
                    if (avg9 <= thr32) begin
                        nxt_phase_state = ST_2PH;
                    end
                end
                ST_2PH: begin
                    if (avg9 <= thr21) begin
                        nxt_phase_state = ST_1PH;
                    end else if (avg9 > thr32 + hyst9) begin
                        nxt_phase_state = ST_3PH;
                    end
                end
                ST_1PH: begin
                    if (avg9 > thr21 + hyst9) begin
                        nxt_phase_state = ST_2PH;
                    end
                end
                default: begin
                    nxt_phase_state = ST_MAX;
                end
            endcase
            // A channel never runs more phases than it has.
            if (MAX_PH < 2) begin
                nxt_phase_state = ST_1PH;
            end else if (MAX_PH < 3 && nxt_phase_state == ST_3PH) begin
                nxt_phase_state = ST_2PH;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            phase_state_ff <= ST_MAX;
        end else begin
            phase_state_ff <= nxt_phase_state;
        end
    end

    // ----------------------------------------------------------------
    // Ramp and conduction mode
    // ----------------------------------------------------------------
    // The undershoot setting is checked first since it reacts to a transient.
    always @* begin
        ramp_step = drop_ramp[`PSR_DRC_RAMP_HI:`PSR_DRC_RAMP_LO];
        if (usr_level1 && usr_sel != 2'h0) begin
            ramp_step = {1'b0, usr_sel - 2'h1};
        end else if (phase_state_ff == ST_2PH && drop_ramp[`PSR_DRC_OV2PH]) begin
            ramp_step = `PSR_RAMP_120MV;
        end else if (phase_state_ff == ST_1PH && drop_ramp[`PSR_DRC_OV1PH]) begin
            ramp_step = `PSR_RAMP_80MV;
        end
        dcm_en = (MAX_PH > 1) && shed_en && shed_th[`PSR_STC_DCM] && phase_state_ff == ST_1PH;
    end

endmodule // psr_shed_ctrl

// ### tb/psr_host.sv
/* Host model that issues one command at a time on the command port.
   Assumes the bench calls xfer from one process only. */
module psr_host (
    input wire logic CLOCK,
    input wire logic RSP_VALID,
    output logic CMD_VALID,
    output logic CMD_READ,
    output logic CMD_IS_WORD,
    output logic [7:0] CMD_CODE,
    output logic [15:0] CMD_WDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Command driver
    // ----------------------------------------
    initial begin
        CMD_VALID = 1'b0;
        CMD_READ = 1'b0;
        CMD_IS_WORD = 1'b0;
        CMD_CODE = 8'h5A;
        CMD_WDATA = 16'hA5A5;
    end
    // Released code and data are inverted so a stale code is never mistaken for live data.
    task automatic xfer(input logic rd, input logic wd, input logic [7:0] code, input logic [15:0] data,
                        output logic ok);
        @(posedge CLOCK);
        CMD_VALID <= 1'b1;
        CMD_READ <= rd;
        CMD_IS_WORD <= wd;
        CMD_CODE <= code;
        CMD_WDATA <= data;
        @(posedge CLOCK);
        CMD_VALID <= 1'b0;
        CMD_CODE <= ~code;
        CMD_WDATA <= ~data;
        #1;
        ok = RSP_VALID;
    endtask
endmodule // psr_host

// ### tb/psr_config_regs_asserts.sv
/* Port checker for the paged configuration registers.
   Assumes it is bound to the register block and sees only its ports. */
`include "psr_consts.vh"
module psr_regs_chk (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic CMD_VALID,
    input wire logic CMD_READ,
    input wire logic CMD_IS_WORD,
    input wire logic [7:0] CMD_CODE,
    input wire logic [15:0] CMD_WDATA,
    input wire logic RSP_VALID,
    input wire logic RSP_ERROR,
    input wire logic [15:0] RSP_RDATA,
    input wire logic [7:0] PAGE_SEL,
    input wire logic [2:0] PHASE_STATE_A,
    input wire logic DCM_ENABLE_B
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);
    rsp_follows_a: assert property (CMD_VALID |=> RSP_VALID) else $error("command not answered");
    rsp_caused_a: assert property (RSP_VALID |-> $past(CMD_VALID)) else $error("answer without command");
    byte_refused_a: assert property (CMD_VALID && !CMD_IS_WORD &&
        (CMD_CODE == `PSR_CMD_DROP_RAMP || CMD_CODE == `PSR_CMD_SHED_TH) |=> RSP_ERROR && RSP_RDATA == 16'h0000)
        else $error("byte access not refused");
    page_word_a: assert property (CMD_VALID && CMD_IS_WORD && CMD_CODE == `PSR_CMD_PAGE
        |=> RSP_ERROR && $stable(PAGE_SEL)) else $error("word page access accepted");
    page_write_a: assert property (CMD_VALID && !CMD_READ && !CMD_IS_WORD && CMD_CODE == `PSR_CMD_PAGE
        && CMD_WDATA[7:1] == 7'h00 |=> !RSP_ERROR && PAGE_SEL == $past(CMD_WDATA[7:0]))
        else $error("page write lost");
    page_legal_a: assert property (PAGE_SEL[7:1] == 7'h00) else $error("page out of range");
    write_quiet_a: assert property (CMD_VALID && !CMD_READ |=> RSP_RDATA == 16'h0000) else $error("write data");
    no_shed_full_a: assert property (CMD_VALID && !CMD_READ && CMD_IS_WORD && !CMD_WDATA[7] &&
        CMD_CODE == `PSR_CMD_DROP_RAMP && PAGE_SEL == `PSR_PAGE_CH_A ##1 !CMD_VALID
        |-> ##2 PHASE_STATE_A == 3'b001) else $error("phases shed while disabled");
    single_no_dcm_a: assert property (!DCM_ENABLE_B) else $error("discontinuous mode on single phase");
endmodule // psr_regs_chk

bind psr_config_regs psr_regs_chk u_chk (.CLOCK(CLOCK), .RESET(RESET), .CMD_VALID(CMD_VALID),
    .CMD_READ(CMD_READ), .CMD_IS_WORD(CMD_IS_WORD), .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA),
    .RSP_VALID(RSP_VALID), .RSP_ERROR(RSP_ERROR), .RSP_RDATA(RSP_RDATA), .PAGE_SEL(PAGE_SEL),
    .PHASE_STATE_A(PHASE_STATE_A), .DCM_ENABLE_B(DCM_ENABLE_B));

// ### tb/test_phase_shed_ramp_config_regs.sv
/* Self-checking bench for the paged configuration registers.
   Assumes the host model owns the command port and the bench the rest. */
module test_phase_shed_ramp_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals and tasks
    // ----------------------------------------
    localparam logic [15:0] NDR_A = 16'hA405;
    localparam logic [15:0] NST_A = 16'h2001;
    localparam logic [15:0] NDR_B = 16'h5C3A;
    localparam logic [15:0] NST_B = 16'hC002;
    logic CLOCK = 1'b0;
    logic RESET = 1'b1;
    logic CMD_VALID, CMD_READ, CMD_IS_WORD, RSP_VALID, RSP_ERROR, DCM_ENABLE_A, DCM_ENABLE_B, ok;
    logic [7:0] CMD_CODE, PAGE_SEL;
    logic [7:0] AVG_CURRENT_A = 8'h00;
    logic [7:0] AVG_CURRENT_B = 8'h10;
    logic USR_LEVEL1_A = 1'b0;
    logic USR_LEVEL1_B = 1'b1;
    logic [15:0] CMD_WDATA, RSP_RDATA;
    logic [2:0] PHASE_STATE_A, PHASE_STATE_B, RAMP_STEP_A, RAMP_STEP_B;
    int err_total = 0;
    int samples_checked = 0;
    int i;
    always #10 CLOCK = ~CLOCK;
    psr_host host (.CLOCK(CLOCK), .RSP_VALID(RSP_VALID), .CMD_VALID(CMD_VALID), .CMD_READ(CMD_READ),
        .CMD_IS_WORD(CMD_IS_WORD), .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA));
    psr_config_regs dut (.CLOCK(CLOCK), .RESET(RESET), .CMD_VALID(CMD_VALID), .CMD_READ(CMD_READ),
        .CMD_IS_WORD(CMD_IS_WORD), .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA), .NVM_DROP_RAMP_A(NDR_A),
        .NVM_SHED_TH_A(NST_A), .NVM_DROP_RAMP_B(NDR_B), .NVM_SHED_TH_B(NST_B), .AVG_CURRENT_A(AVG_CURRENT_A),
        .AVG_CURRENT_B(AVG_CURRENT_B), .USR_LEVEL1_A(USR_LEVEL1_A), .USR_LEVEL1_B(USR_LEVEL1_B),
        .RSP_VALID(RSP_VALID), .RSP_ERROR(RSP_ERROR), .RSP_RDATA(RSP_RDATA), .PAGE_SEL(PAGE_SEL),
        .PHASE_STATE_A(PHASE_STATE_A), .PHASE_STATE_B(PHASE_STATE_B), .RAMP_STEP_A(RAMP_STEP_A),
        .RAMP_STEP_B(RAMP_STEP_B), .DCM_ENABLE_A(DCM_ENABLE_A), .DCM_ENABLE_B(DCM_ENABLE_B));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic rd, input logic wd, input logic [7:0] code, input logic [15:0] data,
                       input logic err, input logic [15:0] rdata);
        host.xfer(rd, wd, code, data, ok);
        check({14'h0000, ok, RSP_ERROR}, {14'h0000, 1'b1, err});
        check(RSP_RDATA, rdata);
    endtask
    // Fixed wait: state moves one edge after a change and shows one edge later.
    task automatic settle;
        repeat (4) @(posedge CLOCK);
        #1;
    endtask
    task automatic drive_avg(input logic [7:0] v);
        @(posedge CLOCK);
        AVG_CURRENT_A <= v;
        settle;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge CLOCK);
        err_total++;
        summarize;
    end
    initial begin
        repeat (10) @(posedge CLOCK);
        RESET <= 1'b0;
        cmd(1, 1, 8'hDE, 16'h0000, 0, NDR_A);
        cmd(1, 1, 8'hDF, 16'h0000, 0, NST_A);
        cmd(0, 0, 8'h00, 16'h0001, 0, 16'h0000);
        cmd(1, 0, 8'h00, 16'h0000, 0, 16'h0001);
        cmd(1, 1, 8'hDE, 16'h0000, 0, NDR_B);
        cmd(1, 1, 8'hDF, 16'h0000, 0, NST_B);
        cmd(0, 1, 8'hDE, 16'hFC6D, 0, 16'h0000);
        cmd(1, 1, 8'hDE, 16'h0000, 0, 16'hFC6D);
        settle;
        check(16'(RAMP_STEP_B), 16'h0002);
        check(16'(PHASE_STATE_B), 16'h0004);
        cmd(1, 0, 8'hDE, 16'h0000, 1, 16'h0000);
        cmd(0, 1, 8'h00, 16'h0000, 1, 16'h0000);
        cmd(0, 0, 8'h00, 16'h0002, 1, 16'h0000);
        cmd(1, 1, 8'h55, 16'h0000, 1, 16'h0000);
        cmd(1, 0, 8'h00, 16'h0000, 0, 16'h0001);
        cmd(0, 0, 8'h00, 16'h0000, 0, 16'h0000);
        cmd(1, 1, 8'hDE, 16'h0000, 0, NDR_A);
        for (i = 0; i < 8; i++) begin
            cmd(0, 1, 8'hDE, {13'h0000, i[2:0]}, 0, 16'h0000);
            settle;
            check(16'(RAMP_STEP_A), 16'(i));
            check(16'(PHASE_STATE_A), 16'h0001);
        end
        @(posedge CLOCK);
        USR_LEVEL1_A <= 1'b1;
        for (i = 0; i < 4; i++) begin
            cmd(0, 1, 8'hDE, {9'h000, i[1:0], 5'h07}, 0, 16'h0000);
            settle;
            check(16'(RAMP_STEP_A), (i == 0) ? 16'h0007 : 16'(i - 1));
        end
        @(posedge CLOCK);
        USR_LEVEL1_A <= 1'b0;
        drive_avg(8'hFF);
        for (i = 0; i < 4; i++) begin
            cmd(0, 1, 8'hDF, {3'b011, 11'h000, i[1:0]}, 0, 16'h0000);
            cmd(0, 1, 8'hDE, {6'h00, i[1:0], 1'b1, 2'b00, 1'b1, 1'b0, 3'h7}, 0, 16'h0000);
            drive_avg(8'(23 + 6 * i));
            check(16'(PHASE_STATE_A), 16'h0001);
            check(16'(RAMP_STEP_A), 16'h0007);
            drive_avg(8'(22 + 6 * i));
            check(16'(PHASE_STATE_A), 16'h0002);
            check(16'(RAMP_STEP_A), 16'h0002);
            drive_avg(8'hFF);
            check(16'(PHASE_STATE_A), 16'h0001);
        end
        cmd(0, 1, 8'hDF, 16'hA000, 0, 16'h0000);
        cmd(0, 1, 8'hDE, 16'h018F, 0, 16'h0000);
        drive_avg(8'h0C);
        check(16'(PHASE_STATE_A), 16'h0004);
        check(16'(RAMP_STEP_A), 16'h0001);
        check(16'(DCM_ENABLE_A), 16'h0001);
        cmd(0, 1, 8'hDE, 16'h010F, 0, 16'h0000);
        settle;
        check(16'(PHASE_STATE_A), 16'h0001);
        check(16'(DCM_ENABLE_A), 16'h0000);
        summarize;
    end
endmodule // test_phase_shed_ramp_config_regs
